// ==== pkg/rtc_pkg.sv ====
package rtc_pkg;
    // --------------------------------------------------------------
    // timing
    // --------------------------------------------------------------
    localparam int SLOW_CLOCK_HZ = 32768;

    // --------------------------------------------------------------
    // reset values of the software-visible words
    // --------------------------------------------------------------
    localparam logic [31:0] TIME_RESET = 32'h0000_0000;
    localparam logic [31:0] CALENDAR_RESET = 32'h0121_0720;
    localparam logic [31:0] TIME_ALARM_RESET = 32'h0000_0000;
    localparam logic [31:0] CALENDAR_ALARM_RESET = 32'h0101_0000;

    // --------------------------------------------------------------
    // field layouts, msb first
    // --------------------------------------------------------------
    typedef struct packed {
        logic [8:0] unused_hi;
        logic pm;
        logic [5:0] hour;
        logic unused_m;
        logic [6:0] minute;
        logic unused_s;
        logic [6:0] second;
    } time_reg_type;

    typedef struct packed {
        logic [7:0] unused_hi;
        logic hour_en;
        logic pm;
        logic [5:0] hour;
        logic minute_en;
        logic [6:0] minute;
        logic second_en;
        logic [6:0] second;
    } time_alarm_type;

    typedef struct packed {
        logic [1:0] unused_hi;
        logic [5:0] date;
        logic [2:0] day;
        logic [4:0] month;
        logic [7:0] year;
        logic unused_c;
        logic [6:0] cent;
    } calendar_reg_type;

    typedef struct packed {
        logic date_en;
        logic unused_d;
        logic [5:0] date;
        logic month_en;
        logic [1:0] unused_m;
        logic [4:0] month;
        logic [15:0] unused_lo;
    } calendar_alarm_type;

    typedef struct packed {
        logic calendar_event;
        logic time_event;
        logic second_event;
        logic alarm;
        logic update_acknowledge;
    } status_type;

    typedef struct packed {
        logic calendar_alarm;
        logic time_alarm;
        logic calendar;
        logic time_of_day;
    } validity_type;

    localparam logic [1:0] TEV_MINUTE = 2'h0;
    localparam logic [1:0] TEV_HOUR = 2'h1;
    localparam logic [1:0] TEV_MIDNIGHT = 2'h2;
    localparam logic [1:0] TEV_NOON = 2'h3;
    localparam logic [1:0] CEV_WEEK = 2'h0;
    localparam logic [1:0] CEV_MONTH = 2'h1;
    localparam logic [1:0] CEV_YEAR = 2'h2;
    localparam logic [2:0] MONDAY = 3'h1;
endpackage : rtc_pkg

// ==== sim/bcd_calendar_clock_alarm_bench.sv ====
`timescale 1ns/100ps
module bcd_calendar_clock_alarm_bench;
    import rtc_pkg::*;
    // ----------------------------------------------------------
    // stimulus and design
    // ----------------------------------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic slow_reference_clock = 1'b0;
    logic hour_format_register = 1'b0;
    logic time_update_request = 1'b0;
    logic calendar_update_request = 1'b0;
    logic [1:0] time_event_select = TEV_MIDNIGHT;
    logic [1:0] calendar_event_select = CEV_YEAR;
    logic [3:0] wr_strobe = 4'h0;
    logic [31:0] write_data = 32'h0;
    status_type status_clear = '0;
    status_type irq_enable = '0;
    time_reg_type time_register;
    calendar_reg_type calendar_register;
    time_alarm_type time_alarm_register;
    calendar_alarm_type calendar_alarm_register;
    status_type status;
    validity_type validity;
    logic irq;
    int err_total = 0;
    int num_checks = 0;
    integer seed = 32'h4318AA5A;
    logic [31:0] t_exp;
    int n;

    always #12.5 clk = ~clk;
    // short second keeps rollover scenarios within a few thousand cycles
    always begin
        repeat (2) @(posedge clk);
        #1 slow_reference_clock = ~slow_reference_clock;
    end

    bcd_calendar_clock_alarm #(.TICKS_PER_SECOND(4)) DUT (
        .clk(clk), .rst(rst), .slow_reference_clock(slow_reference_clock),
        .hour_format_register(hour_format_register),
        .time_update_request(time_update_request),
        .calendar_update_request(calendar_update_request),
        .time_event_select(time_event_select), .calendar_event_select(calendar_event_select),
        .time_write(wr_strobe[0]), .calendar_write(wr_strobe[1]),
        .time_alarm_write(wr_strobe[2]), .calendar_alarm_write(wr_strobe[3]),
        .write_data(write_data), .status_clear(status_clear), .irq_enable(irq_enable),
        .time_register(time_register), .calendar_register(calendar_register),
        .time_alarm_register(time_alarm_register),
        .calendar_alarm_register(calendar_alarm_register),
        .status(status), .validity(validity), .irq(irq));

    // ----------------------------------------------------------
    // helpers
    // ----------------------------------------------------------
    function automatic logic [7:0] bcd(input int v);
        return 8'((v / 10) * 16 + v % 10);
    endfunction : bcd
    function automatic logic [31:0] mk_time(input logic pm, input int h, m, s);
        return {9'h0, pm, 6'(bcd(h)), 1'b0, 7'(bcd(m)), 1'b0, 7'(bcd(s))};
    endfunction : mk_time
    function automatic logic [31:0] mk_cal(input int c, y, mo, d, wd);
        return {2'h0, 6'(bcd(d)), 3'(wd), 5'(bcd(mo)), bcd(y), 1'b0, 7'(bcd(c))};
    endfunction : mk_cal
    task automatic cyc;
        @(posedge clk);
        #1;
    endtask : cyc
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    // counting runs apart from the reader, so a value is read twice and, if the two reads differ, read once more
    task automatic rd_agree(output logic [31:0] v);
        logic [31:0] a;
        a = time_register;
        cyc;
        v = time_register;
        if (v !== a) begin
            cyc;
            v = time_register;
        end
    endtask : rd_agree
    task automatic wr(input int k, input logic [31:0] d);
        cyc;
        wr_strobe = 4'h1 << k;
        write_data = d;
        cyc;
        wr_strobe = 4'h0;
    endtask : wr
    task automatic clr(input status_type m);
        cyc;
        status_clear = m;
        cyc;
        status_clear = '0;
    endtask : clr
    task automatic wait_flag(input int lim, input int bitno);
        n = 0;
        while (status[bitno] !== 1'b1 && n < lim) begin
            cyc;
            n++;
        end
        chk(32'(status[bitno]), 32'h1, "status flag timeout");
    endtask : wait_flag
    task automatic conclude;
        if (err_total == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude

    initial begin
        #(25 * 20000);
        err_total++;
        conclude;
    end

    // ----------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk);
        #1;
        rst = 1'b0;
        chk(time_register, TIME_RESET, "time reset");
        chk(calendar_register, CALENDAR_RESET, "calendar reset");
        chk(time_alarm_register, TIME_ALARM_RESET, "alarm reset");
        chk(calendar_alarm_register, CALENDAR_ALARM_RESET, "cal alarm reset");
        chk(32'({status, validity, irq}), 32'h0, "flags reset");
        time_update_request = 1'b1;
        wait_flag(200, 0);
        clr(5'h01);
        chk(32'(status.update_acknowledge), 32'h0, "ack clear");
        for (int i = 0; i < 6; i++) begin
            t_exp = mk_time(1'b0, {$random(seed)} % 24, {$random(seed)} % 60,
                            {$random(seed)} % 60);
            wr(0, t_exp);
            chk(time_register, t_exp, "time write");
        end
        repeat (40) cyc;
        chk(time_register, t_exp, "frozen time");
        wr(0, t_exp | 32'h0000_6000);
        chk(time_register, t_exp, "bad minute kept");
        chk(32'(validity), 32'h1, "bad minute flagged");
        wr(0, t_exp | 32'h0000_005A);
        chk(time_register, t_exp, "bad second kept");
        wr(0, mk_time(1'b1, 12, 0, 0));
        chk(time_register, t_exp, "pm in 24h kept");
        hour_format_register = 1'b1;
        wr(0, mk_time(1'b1, 11, 30, 0));
        chk(time_register, mk_time(1'b1, 23, 30, 0), "12h readback");
        chk(32'(validity), 32'h0, "good write clears");
        wr(0, mk_time(1'b0, 13, 0, 0));
        chk(32'(validity), 32'h1, "12h range");
        hour_format_register = 1'b0;
        wr(1, mk_cal(19, 0, 2, 29, 1));
        chk(32'(validity), 32'h3, "1900 common year");
        wr(1, mk_cal(21, 4, 1, 1, 1));
        chk(calendar_register, CALENDAR_RESET, "century range");
        wr(1, mk_cal(20, 4, 4, 31, 1));
        chk(calendar_register, CALENDAR_RESET, "month vs date");
        wr(1, mk_cal(20, 4, 2, 29, 0));
        chk(calendar_register, CALENDAR_RESET, "weekday range");
        wr(1, mk_cal(20, 4, 2, 29, 7));
        chk(calendar_register, mk_cal(20, 4, 2, 29, 7), "leap day");
        wr(1, mk_cal(20, 3, 12, 31, 7));
        wr(0, mk_time(1'b0, 23, 59, 58));
        chk(32'(validity), 32'h0, "all good");
        // value first with the enable clear, then the enable
        wr(2, 32'h0000_0005);
        wr(2, 32'h0000_0085);
        chk(time_alarm_register, 32'h0000_0085, "alarm enable");
        irq_enable = 5'h02;
        time_update_request = 1'b0;
        clr(5'h1F);
        n = 0;
        while (time_register.second !== 7'h00 && n < 200) begin
            cyc;
            n++;
        end
        repeat (2) cyc;
        rd_agree(t_exp);
        chk(t_exp, mk_time(1'b0, 0, 0, 0), "midnight");
        chk(calendar_register, mk_cal(20, 4, 1, 1, 1), "new year");
        chk(32'(status[4:2]), 32'h7, "day, year and second events");
        wait_flag(200, 1);
        chk(time_register, mk_time(1'b0, 0, 0, 5), "alarm second");
        chk(32'(irq), 32'h1, "irq raised");
        clr(5'h02);
        chk(32'({status.alarm, irq}), 32'h0, "alarm cleared");
        wait_flag(1100, 1);
        chk(time_register, mk_time(1'b0, 0, 1, 5), "alarm next minute");
        time_event_select = TEV_MINUTE;
        clr(5'h08);
        wait_flag(1100, 3);
        chk(time_register, mk_time(1'b0, 0, 2, 0), "minute event");
        // calendar-only hold: time keeps counting while the calendar is written
        calendar_update_request = 1'b1;
        wait_flag(200, 0);
        t_exp = time_register;
        clr(5'h01);
        wr(1, mk_cal(20, 99, 12, 31, 5));
        repeat (20) cyc;
        chk(calendar_register, mk_cal(20, 99, 12, 31, 5), "calendar-only write");
        chk(32'(time_register != t_exp), 32'h1, "time runs in calendar hold");
        calendar_update_request = 1'b0;
        conclude;
    end
endmodule : bcd_calendar_clock_alarm_bench

// ==== verilog/bcd_calendar_clock_alarm.sv ====
`timescale 1ns/100ps
// Functional notes
// - counting runs from the 32.768 kHz slow reference, unaffected by power settings
// - all values kept in BCD; hour always shown 24-hour, with PM set from the hour in 12-hour mode
// - century, year, month, date, weekday, hour, minute, second all readable
// - calendar only needs to be right through year 2099
// - February has 29 days when year divisible by 4, except 1900
// - seconds tick each second; each higher counter steps on lower rollover
// - alarm compares five fields, each enabled; all enabled matches set flag
// - seconds-only alarm fires once per minute at the programmed second
// - time alarm enables write independently of their value fields
// - failed entry check keeps stored value and sets validity flag
// - validity flag clears only when a good value is written
// - century must be 19 or 20, year legal two-digit BCD
// - date 01-31, month 01-12 consistent with date and year, weekday 1-7
// - 24-hour: hour 00-23, PM clear; 12-hour: hour 01-12
// - minute and second must be BCD in 00-59
// - 12-hour writes read back as the equivalent 24-hour hour
// - the hour format register picks the hour range checked; AM/PM bit 22 must be clear in 24-hour mode
// - interrupt output is shared by ORing, software polls status
// - time, calendar and alarm writes capture a whole 32-bit word
// - update request stops counters, acknowledge within one second, software clears
// - time update stops time and calendar; calendar update only calendar
// - time event select: minute, hour, midnight, noon
// - calendar event select: Monday midnight, first of month, January first
module bcd_calendar_clock_alarm
    import rtc_pkg::*;
#(
    parameter int TICKS_PER_SECOND = rtc_pkg::SLOW_CLOCK_HZ
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic slow_reference_clock,
    input wire logic hour_format_register,
    input wire logic time_update_request,
    input wire logic calendar_update_request,
    input wire logic [1:0] time_event_select,
    input wire logic [1:0] calendar_event_select,
    input wire logic time_write,
    input wire logic calendar_write,
    input wire logic time_alarm_write,
    input wire logic calendar_alarm_write,
    input wire logic [31:0] write_data,
    input wire rtc_pkg::status_type status_clear,
    input wire rtc_pkg::status_type irq_enable,
    output rtc_pkg::time_reg_type time_register,
    output rtc_pkg::calendar_reg_type calendar_register,
    output rtc_pkg::time_alarm_type time_alarm_register,
    output rtc_pkg::calendar_alarm_type calendar_alarm_register,
    output rtc_pkg::status_type status,
    output rtc_pkg::validity_type validity,
    output logic irq
);
    import rtc_pkg::*;

    localparam int CW = $clog2(TICKS_PER_SECOND);
    localparam logic [CW-1:0] LAST_TICK = CW'(TICKS_PER_SECOND - 1);

    // --------------------------------------------------------------
    // bcd helpers
    // --------------------------------------------------------------
    function automatic logic bcd_in(input logic [7:0] v, input logic [7:0] lo,
                                    input logic [7:0] hi);
        return (v[3:0] <= 4'h9) && (v[7:4] <= 4'h9) && (v >= lo) && (v <= hi);
    endfunction : bcd_in

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9)
            return {v[7:4] + 4'h1, 4'h0};
        return {v[7:4], v[3:0] + 4'h1};
    endfunction : bcd_inc

    function automatic logic [5:0] month_days(input logic [4:0] m, input logic [7:0] y,
                                              input logic [6:0] c);
        logic leap;
        leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                    : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
        leap = leap && !(c == 7'h19 && y == 8'h00);
        unique case (m)
            5'h02: return leap ? 6'h29 : 6'h28;
            5'h04, 5'h06, 5'h09, 5'h11: return 6'h30;
            default: return 6'h31;
        endcase
    endfunction : month_days

    function automatic logic hour_ok(input logic [5:0] h, input logic pm, input logic fmt);
        if (fmt)
            return bcd_in({2'h0, h}, 8'h01, 8'h12);
        return bcd_in({2'h0, h}, 8'h00, 8'h23) && !pm;
    endfunction : hour_ok

    // 12-hour entries are stored as 24-hour so reads stay unambiguous
    function automatic logic [5:0] to_24(input logic [5:0] h, input logic pm, input logic fmt);
        logic [7:0] s;
        if (!fmt)
            return h;
        if (h == 6'h12)
            return pm ? 6'h12 : 6'h00;
        if (!pm)
            return h;
        s = {4'h0, h[3:0]} + 8'h02;
        if (s[3:0] > 4'h9)
            return {h[5:4] + 2'h2, s[3:0] - 4'hA};
        return {h[5:4] + 2'h1, s[3:0]};
    endfunction : to_24

    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    time_reg_type tm_q, tm_d;
    calendar_reg_type cal_q, cal_d;
    time_alarm_type tal_q, tal_d;
    calendar_alarm_type cal_al_q, cal_al_d;
    status_type status_q, status_d;
    validity_type valid_q, valid_d;
    logic [CW-1:0] ref_cnt_q, ref_cnt_d;
    logic slow_q, frozen_q, frozen_d, fmt_q;
    logic slow_edge, sec_tick, time_run, cal_run, step, day_roll, noon, midnight;
    logic accept_time, accept_cal, time_ok, cal_ok, tal_ok, cal_al_ok, match, any_en;
    time_reg_type wt;
    calendar_reg_type wc;
    time_alarm_type wta;
    calendar_alarm_type wca;

    always_comb begin
        tm_d = tm_q;
        cal_d = cal_q;
        tal_d = tal_q;
        cal_al_d = cal_al_q;
        valid_d = valid_q;
        day_roll = 1'b0;
        noon = 1'b0;
        midnight = 1'b0;
        // --------------------------------------------------------------
        // one-second base from the slow reference
        // --------------------------------------------------------------
        slow_edge = slow_reference_clock && !slow_q;
        sec_tick = slow_edge && (ref_cnt_q == LAST_TICK);
        ref_cnt_d = ref_cnt_q;
        if (slow_edge)
            ref_cnt_d = sec_tick ? '0 : ref_cnt_q + CW'(1);
        time_run = !time_update_request;
        cal_run = !time_update_request && !calendar_update_request;
        step = sec_tick && time_run;
        // --------------------------------------------------------------
        // counting
        // --------------------------------------------------------------
        if (step) begin
            tm_d.second = 7'(bcd_inc({1'b0, tm_q.second}));
            if (tm_q.second == 7'h59) begin
                tm_d.second = 7'h00;
                tm_d.minute = 7'(bcd_inc({1'b0, tm_q.minute}));
                if (tm_q.minute == 7'h59) begin
                    tm_d.minute = 7'h00;
                    tm_d.hour = 6'(bcd_inc({2'h0, tm_q.hour}));
                    noon = (tm_q.hour == 6'h11);
                    if (tm_q.hour == 6'h23) begin
                        tm_d.hour = 6'h00;
                        day_roll = 1'b1;
                        midnight = 1'b1;
                    end
                end
            end
        end
        if (day_roll && cal_run) begin
            cal_d.day = (cal_q.day == 3'h7) ? 3'h1 : cal_q.day + 3'h1;
            cal_d.date = 6'(bcd_inc({2'h0, cal_q.date}));
            if (cal_q.date == month_days(cal_q.month, cal_q.year, cal_q.cent)) begin
                cal_d.date = 6'h01;
                cal_d.month = 5'(bcd_inc({3'h0, cal_q.month}));
                if (cal_q.month == 5'h12) begin
                    cal_d.month = 5'h01;
                    cal_d.year = bcd_inc(cal_q.year);
                    if (cal_q.year == 8'h99) begin
                        cal_d.year = 8'h00;
                        // past 2099 the century just keeps counting
                        cal_d.cent = 7'(bcd_inc({1'b0, cal_q.cent}));
                    end
                end
            end
        end
        // --------------------------------------------------------------
        // whole-word writes with entry checks
        // --------------------------------------------------------------
        wt = time_reg_type'(write_data);
        wc = calendar_reg_type'(write_data);
        wta = time_alarm_type'(write_data);
        wca = calendar_alarm_type'(write_data);
        accept_time = time_write && time_update_request && frozen_q;
        accept_cal = calendar_write && (time_update_request || calendar_update_request)
                     && frozen_q;
        time_ok = bcd_in({1'b0, wt.second}, 8'h00, 8'h59)
                  && bcd_in({1'b0, wt.minute}, 8'h00, 8'h59)
                  && hour_ok(wt.hour, wt.pm, fmt_q);
        cal_ok = (wc.cent == 7'h19 || wc.cent == 7'h20)
                 && bcd_in(wc.year, 8'h00, 8'h99)
                 && bcd_in({2'h0, wc.date}, 8'h01, 8'h31)
                 && bcd_in({3'h0, wc.month}, 8'h01, 8'h12)
                 && wc.date <= month_days(wc.month, wc.year, wc.cent)
                 && wc.day >= 3'h1 && wc.day <= 3'h7;
        tal_ok = bcd_in({1'b0, wta.second}, 8'h00, 8'h59)
                 && bcd_in({1'b0, wta.minute}, 8'h00, 8'h59)
                 && hour_ok(wta.hour, wta.pm, fmt_q);
        cal_al_ok = bcd_in({3'h0, wca.month}, 8'h01, 8'h12)
                    && bcd_in({2'h0, wca.date}, 8'h01, 8'h31);
        if (accept_time) begin
            valid_d.time_of_day = !time_ok;
            if (time_ok) begin
                tm_d = '0;
                tm_d.second = wt.second;
                tm_d.minute = wt.minute;
                tm_d.hour = to_24(wt.hour, wt.pm, fmt_q);
            end
        end
        if (accept_cal) begin
            valid_d.calendar = !cal_ok;
            if (cal_ok)
                cal_d = wc;
            cal_d.unused_hi = 2'h0;
            cal_d.unused_c = 1'b0;
        end
        if (time_alarm_write) begin
            valid_d.time_alarm = !tal_ok;
            tal_d.second_en = wta.second_en;
            tal_d.minute_en = wta.minute_en;
            tal_d.hour_en = wta.hour_en;
            if (tal_ok) begin
                tal_d.second = wta.second;
                tal_d.minute = wta.minute;
                tal_d.hour = to_24(wta.hour, wta.pm, fmt_q);
            end
        end
        if (calendar_alarm_write) begin
            valid_d.calendar_alarm = !cal_al_ok;
            cal_al_d.date_en = wca.date_en;
            cal_al_d.month_en = wca.month_en;
            if (cal_al_ok) begin
                cal_al_d.date = wca.date;
                cal_al_d.month = wca.month;
            end
        end
        // --------------------------------------------------------------
        // alarm and events; a set beats a same-cycle clear
        // --------------------------------------------------------------
        any_en = tal_q.second_en || tal_q.minute_en || tal_q.hour_en
                 || cal_al_q.date_en || cal_al_q.month_en;
        match = any_en
                && (!tal_q.second_en || tm_d.second == tal_q.second)
                && (!tal_q.minute_en || tm_d.minute == tal_q.minute)
                && (!tal_q.hour_en || tm_d.hour == tal_q.hour)
                && (!cal_al_q.date_en || cal_d.date == cal_al_q.date)
                && (!cal_al_q.month_en || cal_d.month == cal_al_q.month);
        status_d = status_q & ~status_clear;
        if (sec_tick && (time_update_request || calendar_update_request) && !frozen_q)
            status_d.update_acknowledge = 1'b1;
        if (step && match)
            status_d.alarm = 1'b1;
        if (step)
            status_d.second_event = 1'b1;
        unique case (time_event_select)
            TEV_MINUTE: status_d.time_event |= step && tm_q.second == 7'h59;
            TEV_HOUR: status_d.time_event |= step && tm_d.hour != tm_q.hour;
            TEV_MIDNIGHT: status_d.time_event |= midnight;
            TEV_NOON: status_d.time_event |= noon;
        endcase
        if (day_roll && cal_run) begin
            if (calendar_event_select == CEV_WEEK && cal_d.day == MONDAY)
                status_d.calendar_event = 1'b1;
            if (calendar_event_select == CEV_MONTH && cal_d.date == 6'h01)
                status_d.calendar_event = 1'b1;
            if (calendar_event_select == CEV_YEAR && cal_d.date == 6'h01
                && cal_d.month == 5'h01)
                status_d.calendar_event = 1'b1;
        end
        frozen_d = (time_update_request || calendar_update_request)
                   && (frozen_q || sec_tick);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tm_q <= time_reg_type'(TIME_RESET);
            cal_q <= calendar_reg_type'(CALENDAR_RESET);
            tal_q <= time_alarm_type'(TIME_ALARM_RESET);
            cal_al_q <= calendar_alarm_type'(CALENDAR_ALARM_RESET);
            status_q <= '0;
            valid_q <= '0;
            ref_cnt_q <= '0;
            slow_q <= 1'b0;
            frozen_q <= 1'b0;
            fmt_q <= 1'b0;
        end else begin
            tm_q <= tm_d;
            cal_q <= cal_d;
            tal_q <= tal_d;
            cal_al_q <= cal_al_d;
            status_q <= status_d;
            valid_q <= valid_d;
            ref_cnt_q <= ref_cnt_d;
            slow_q <= slow_reference_clock;
            frozen_q <= frozen_d;
            fmt_q <= hour_format_register;
        end
    end

    // --------------------------------------------------------------
    // read side
    // --------------------------------------------------------------
    always_comb begin
        time_register = tm_q;
        time_register.pm = fmt_q && (tm_q.hour >= 6'h12);
    end
    assign calendar_register = cal_q;
    assign time_alarm_register = tal_q;
    assign calendar_alarm_register = cal_al_q;
    assign status = status_q;
    assign validity = valid_q;
    assign irq = |(status_q & irq_enable);

    // --------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_ack_on_tick;
        $rose(status_q.update_acknowledge) |-> $past(sec_tick) && frozen_q;
    endproperty
    a_ack_on_tick: assert property (p_ack_on_tick) else $error("ack off tick");
    property p_time_stop;
        time_update_request && !time_write && !calendar_write
            |=> $stable(tm_q) && $stable(cal_q);
    endproperty
    a_time_stop: assert property (p_time_stop) else $error("counting while stopped");
    property p_cal_only;
        calendar_update_request && !time_update_request && !calendar_write && sec_tick
            |=> tm_q.second != $past(tm_q.second) && $stable(cal_q);
    endproperty
    a_cal_only: assert property (p_cal_only) else $error("calendar hold wrong");
    property p_reject;
        accept_time && !time_ok |=> $stable(tm_q) && valid_q.time_of_day;
    endproperty
    a_reject: assert property (p_reject) else $error("bad time loaded");
    property p_good_clears;
        accept_time && time_ok |=> !valid_q.time_of_day && tm_q.second == $past(wt.second);
    endproperty
    a_good_clears: assert property (p_good_clears) else $error("good time lost");
    property p_sec_step;
        step |=> tm_q.second != $past(tm_q.second);
    endproperty
    a_sec_step: assert property (p_sec_step) else $error("second missed");
    property p_seconds_alarm;
        step && tal_q.second_en && !tal_q.minute_en && !tal_q.hour_en && !cal_al_q.date_en
            && !cal_al_q.month_en && tm_d.second == tal_q.second |=> status_q.alarm;
    endproperty
    a_seconds_alarm: assert property (p_seconds_alarm) else $error("alarm missed");
    property p_weekday_wrap;
        day_roll && cal_run && cal_q.day == 3'h7 |=> cal_q.day == 3'h1;
    endproperty
    a_weekday_wrap: assert property (p_weekday_wrap) else $error("weekday wrap");
    property p_pm_hour;
        accept_time && time_ok && fmt_q && wt.pm && wt.hour == 6'h01 |=> tm_q.hour == 6'h13;
    endproperty
    a_pm_hour: assert property (p_pm_hour) else $error("12h convert");
    property p_bcd_kept;
        tm_q.second[3:0] <= 4'h9 && tm_q.hour <= 6'h23 && cal_q.date[3:0] <= 4'h9;
    endproperty
    a_bcd_kept: assert property (p_bcd_kept) else $error("non-bcd state");

    c_midnight: cover property (midnight && cal_run);
    c_alarm: cover property (step && match);
    c_reject: cover property (accept_cal && !cal_ok);
    c_ack: cover property ($rose(status_q.update_acknowledge));
endmodule : bcd_calendar_clock_alarm
